/* hdl/tgc_core.sv */
// gated 16-bit timer/counter core with byte-wide register port
// assumes synchronous pins; clk is the oscillator, the instruction cycle is four clocks
//
// Behaviour
// - the counter is 16 bits, read and written as a low byte and a high byte.
// - writing either byte loads that half of the running counter directly.
// - clock select 0 counts instruction cycles, 1 counts the external source.
// - on the internal source each increment spans prescale-ratio instruction cycles.
// - internal source makes a timer only; external source serves as timer or counter.
// - in external mode the counter advances on rising edges of the count input.
// - the external source either passes a synchroniser or bypasses it.
// - with the internal oscillator and no clock output the crystal input may clock it.
// - after enabling, a falling edge must be seen before the first counting edge.
// - the count gate comes from the comparator output or from the gate pin.
// - overflow may wake the device only when clocked externally and unsynchronised.
// - the comparator output may be resampled on the counter's own clock.
// - a 1/2/4/8 prescaler, invisible to software, is cleared by any counter write.
// - with sync disabled the external source counts without the phase clocks.
// - rolling from ffff to 0000 sets a sticky overflow flag until software clears it.
// - a special event trigger clears the counter with no overflow; a write wins over it.
`timescale 1ns/1ns
module tgc_core (
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   input  wire logic [tgc_pkg::ADDR_W-1:0]    reg_addr,
   input  wire logic [tgc_pkg::DATA_W-1:0]    reg_wdata,
   input  wire logic                          reg_wr,
   input  wire logic                          reg_rd,
   output logic      [tgc_pkg::DATA_W-1:0]    reg_rdata,
   input  wire logic                          external_count_input,
   input  wire logic                          low_power_crystal_osc,
   input  wire logic                          internal_oscillator_no_clock_output_pin,
   input  wire logic                          gate_input_pin,
   input  wire logic                          comparator_out,
   input  wire logic                          special_event_trigger,
   input  wire logic                          sleep_mode,
   output logic                               irq,
   output logic                               wake_req,
   output logic                               comparator_sync_out
);
   import tgc_pkg::*;

   logic [15:0] count;
   logic [15:0] next_count;
   logic [7:0]  ctrl;
   logic [1:0]  gcfg;
   logic        overflow_flag;
   logic        ovf_mask;
   logic [1:0]  phase;
   logic        cmp_held;
   logic        ovf_event;

   logic        module_on;
   logic        count_clock_select;
   logic        sync_disable;
   logic        lp_osc_en;
   tgc_ps_t     prescale_select;
   logic        gate_enable;
   logic        gate_invert;
   logic        gate_src_cmp;
   logic        cmp_sync_en;

   logic        wr_low;
   logic        wr_high;
   logic        wr_ctrl;
   logic        wr_stat;
   logic        wr_mask;
   logic        wr_gcfg;
   logic        cnt_write;
   logic        ext_src;
   logic        ext_rise;
   logic        instr_tick;
   logic        cmp_level;
   logic        gate_open;
   logic        run_ok;
   logic        inc;
   logic        src_tick;

   tgc_tick_if  tk ();

   // control fields
   assign module_on          = ctrl[CTRL_ON];
   assign count_clock_select = ctrl[CTRL_CS];
   assign sync_disable       = ctrl[CTRL_SYNCD];
   assign lp_osc_en          = ctrl[CTRL_LPOSC];
   assign prescale_select    = ctrl[CTRL_PS_HI:CTRL_PS_LO];
   assign gate_enable        = ctrl[CTRL_GEN];
   assign gate_invert        = ctrl[CTRL_GINV];
   assign gate_src_cmp       = gcfg[GCFG_SRC];
   assign cmp_sync_en        = gcfg[GCFG_CSYNC];

   // address decode
   assign wr_low    = reg_wr & (reg_addr == OFS_LOW);
   assign wr_high   = reg_wr & (reg_addr == OFS_HIGH);
   assign wr_ctrl   = reg_wr & (reg_addr == OFS_CTRL);
   assign wr_stat   = reg_wr & (reg_addr == OFS_STATUS);
   assign wr_mask   = reg_wr & (reg_addr == OFS_MASK);
   assign wr_gcfg   = reg_wr & (reg_addr == OFS_GATE);
   assign cnt_write = wr_low | wr_high;

   // crystal only usable when the system is not using it for its own clock
   assign ext_src = (lp_osc_en & internal_oscillator_no_clock_output_pin) ?
                    low_power_crystal_osc : external_count_input;

   tgc_edge u_edge (
      .clk     (clk),
      .sys_rst (sys_rst),
      .src     (ext_src),
      .bypass  (sync_disable),
      .enable  (module_on & count_clock_select),
      .rise    (ext_rise)
   );

   // instruction clock: one tick per four oscillator periods
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase <= 2'h0;
      end else if (!sleep_mode) begin
         phase <= 2'(phase + 2'h1);
      end
   end
   assign instr_tick = (phase == PHASE_LAST) & ~sleep_mode;

   // gate source select and polarity, comparator optionally resampled
   assign cmp_level = cmp_sync_en ? cmp_held : comparator_out;
   assign gate_open = ~gate_enable |
                      (gate_invert ^ (gate_src_cmp ? cmp_level : gate_input_pin));

   // in sleep only the unsynchronised external path keeps running
   assign run_ok = ~sleep_mode | (count_clock_select & sync_disable);

   // internal source is always a timer; external may be timer or event counter
   assign src_tick   = module_on & run_ok &
                       (count_clock_select ? ext_rise : instr_tick);
   // gate sits after the raw tick so a resampled comparator can still reopen it
   assign tk.tick_in = src_tick & gate_open;
   assign tk.clear   = cnt_write;
   assign tk.sel     = prescale_select;

   tgc_prescale u_pre (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tk      (tk.pre)
   );

   assign inc       = tk.tick_out;
   assign ovf_event = inc & (count == COUNT_MAX) & ~cnt_write & ~special_event_trigger;

   // next count: write beats trigger beats increment
   always_comb begin
      next_count = count;
      if (cnt_write) begin
         if (wr_low) begin
            next_count[7:0] = reg_wdata;
         end else begin
            next_count[15:8] = reg_wdata;
         end
      end else if (special_event_trigger) begin
         next_count = COUNT_RST;
      end else if (inc) begin
         next_count = 16'(count + 16'h1);
      end
   end

   // counter and comparator resample register
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         count    <= COUNT_RST;
         cmp_held <= 1'b0;
      end else begin
         count <= next_count;
         if (src_tick) begin
            cmp_held <= comparator_out;
         end
      end
   end
   assign comparator_sync_out = cmp_held;

   // software registers; a new overflow wins over a clearing write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl          <= CTRL_RST;
         gcfg          <= GCFG_RST;
         ovf_mask      <= 1'b0;
         overflow_flag <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= reg_wdata;
         end
         if (wr_gcfg) begin
            gcfg <= reg_wdata[1:0];
         end
         if (wr_mask) begin
            ovf_mask <= reg_wdata[STAT_OVF];
         end
         if (ovf_event) begin
            overflow_flag <= 1'b1;
         end else if (wr_stat && reg_wdata[STAT_OVF]) begin
            overflow_flag <= 1'b0;
         end
      end
   end

   assign irq      = overflow_flag & ovf_mask;
   // wake only from the free-running unsynchronised external path
   assign wake_req = sleep_mode & irq & count_clock_select & sync_disable;

   // read data one cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (sys_rst || !reg_rd) begin
         reg_rdata <= 8'h00;
      end else begin
         unique case (reg_addr)
            OFS_LOW:    reg_rdata <= count[7:0];
            OFS_HIGH:   reg_rdata <= count[15:8];
            OFS_CTRL:   reg_rdata <= ctrl;
            OFS_STATUS: reg_rdata <= {7'h00, overflow_flag};
            OFS_MASK:   reg_rdata <= {7'h00, ovf_mask};
            OFS_GATE:   reg_rdata <= {6'h00, gcfg};
            default:    reg_rdata <= 8'h00;
         endcase
      end
   end

   property p_load_low;
      @(posedge clk) disable iff (sys_rst)
         wr_low |=> (count[7:0] == $past(reg_wdata));
   endproperty
   a_load_low: assert property (p_load_low) else $error("low byte write lost");

   property p_load_high;
      @(posedge clk) disable iff (sys_rst)
         wr_high |=> (count[15:8] == $past(reg_wdata)) && (count[7:0] == $past(count[7:0]));
   endproperty
   a_load_high: assert property (p_load_high) else $error("high byte write lost");

   property p_trig_clear;
      @(posedge clk) disable iff (sys_rst)
         (special_event_trigger && !cnt_write && !overflow_flag && !wr_stat)
            |=> (count == COUNT_RST) && !overflow_flag;
   endproperty
   a_trig_clear: assert property (p_trig_clear) else $error("trigger clear wrong");

   property p_rollover;
      @(posedge clk) disable iff (sys_rst)
         (count == COUNT_MAX && inc && !cnt_write && !special_event_trigger)
            |=> (count == COUNT_RST) && overflow_flag;
   endproperty
   a_rollover: assert property (p_rollover) else $error("overflow flag not set");

   property p_flag_sticky;
      @(posedge clk) disable iff (sys_rst)
         (overflow_flag && !(wr_stat && reg_wdata[STAT_OVF])) |=> overflow_flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("overflow flag dropped");

   property p_hold_off;
      @(posedge clk) disable iff (sys_rst)
         (!module_on && !cnt_write && !special_event_trigger) |=> (count == $past(count));
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("counter moved while off");

   property p_internal_rate;
      @(posedge clk) disable iff (sys_rst)
         (!count_clock_select && inc) |-> (phase == PHASE_LAST);
   endproperty
   a_internal_rate: assert property (p_internal_rate) else $error("tick off cycle");

   property p_wake_async;
      @(posedge clk) disable iff (sys_rst)
         wake_req |-> (count_clock_select && sync_disable && overflow_flag);
   endproperty
   a_wake_async: assert property (p_wake_async) else $error("wake from wrong mode");

   property p_gate_hold;
      @(posedge clk) disable iff (sys_rst)
         (!gate_open && !cnt_write && !special_event_trigger) |=> (count == $past(count));
   endproperty
   a_gate_hold: assert property (p_gate_hold) else $error("counted through closed gate");

   property p_sleep_hold;
      @(posedge clk) disable iff (sys_rst)
         (sleep_mode && !(count_clock_select && sync_disable) && !cnt_write
            && !special_event_trigger) |=> (count == $past(count));
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("counted in sleep");

   property p_cmp_resample;
      @(posedge clk) disable iff (sys_rst)
         src_tick |=> (cmp_held == $past(comparator_out));
   endproperty
   a_cmp_resample: assert property (p_cmp_resample) else $error("comparator not resampled");

   property p_trig_no_flag;
      @(posedge clk) disable iff (sys_rst)
         (special_event_trigger && !overflow_flag) |=> !overflow_flag;
   endproperty
   a_trig_no_flag: assert property (p_trig_no_flag) else $error("trigger raised overflow");

   property p_rdata_idle;
      @(posedge clk) disable iff (sys_rst)
         !reg_rd |=> (reg_rdata == 8'h00);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without strobe");
endmodule

/* hdl/tgc_pkg.sv */
// constants shared by the gated 16-bit timer/counter core and its helpers
// assumes a single system clock that also stands for the oscillator
package tgc_pkg;
   localparam int unsigned ADDR_W      = 3;
   localparam int unsigned DATA_W      = 8;
   // register offsets
   localparam logic [2:0]  OFS_LOW     = 3'h0;
   localparam logic [2:0]  OFS_HIGH    = 3'h1;
   localparam logic [2:0]  OFS_CTRL    = 3'h2;
   localparam logic [2:0]  OFS_STATUS  = 3'h3;
   localparam logic [2:0]  OFS_MASK    = 3'h4;
   localparam logic [2:0]  OFS_GATE    = 3'h5;
   // control register fields
   localparam int unsigned CTRL_ON     = 0;
   localparam int unsigned CTRL_CS     = 1;
   localparam int unsigned CTRL_SYNCD  = 2;
   localparam int unsigned CTRL_LPOSC  = 3;
   localparam int unsigned CTRL_PS_LO  = 4;
   localparam int unsigned CTRL_PS_HI  = 5;
   localparam int unsigned CTRL_GEN    = 6;
   localparam int unsigned CTRL_GINV   = 7;
   // gate configuration fields
   localparam int unsigned GCFG_SRC    = 0;
   localparam int unsigned GCFG_CSYNC  = 1;
   // status and mask fields
   localparam int unsigned STAT_OVF    = 0;
   // reset values
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic [1:0]  GCFG_RST    = 2'h0;
   localparam logic [15:0] COUNT_RST   = 16'h0000;
   localparam logic [15:0] COUNT_MAX   = 16'hffff;
   // oscillator periods per instruction cycle
   localparam int unsigned INSTR_DIV   = 4;
   localparam logic [1:0]  PHASE_LAST  = 2'(INSTR_DIV - 1);
   typedef logic [1:0] tgc_ps_t;
endpackage

/* hdl/tgc_tick_if.sv */
// count tick path between the core and its prescaler
// assumes both ends run on the same system clock
`timescale 1ns/1ns
interface tgc_tick_if;
   import tgc_pkg::*;
   logic    tick_in;
   logic    clear;
   tgc_ps_t sel;
   logic    tick_out;
   modport pre  (input tick_in, input clear, input sel, output tick_out);
   modport core (output tick_in, output clear, output sel, input tick_out);
endinterface

/* hdl/tgc_prescale.sv */
// prescaler dividing count ticks by 1, 2, 4 or 8; not visible to software
// assumes clear comes from a software write to either counter byte
`timescale 1ns/1ns
module tgc_prescale (
   input  wire logic  clk,
   input  wire logic  sys_rst,
   tgc_tick_if.pre    tk
);
   import tgc_pkg::*;

   logic [2:0] cnt;
   logic [2:0] lim;

   // ratio 2^sel, wrap point is ratio minus one
   assign lim         = 3'((4'h1 << tk.sel) - 4'h1);
   assign tk.tick_out = tk.tick_in & (cnt == lim) & ~tk.clear;

   // counter of pending input ticks
   always_ff @(posedge clk) begin
      if (sys_rst || tk.clear) begin
         cnt <= 3'h0;
      end else if (tk.tick_in) begin
         cnt <= (cnt == lim) ? 3'h0 : 3'(cnt + 3'h1);
      end
   end

   property p_pre_clr;
      @(posedge clk) disable iff (sys_rst) tk.clear |=> (cnt == 3'h0);
   endproperty
   a_pre_clr: assert property (p_pre_clr) else $error("prescaler not cleared");

   property p_pre_div1;
      @(posedge clk) disable iff (sys_rst)
         (tk.sel == 2'h0 && tk.tick_in && !tk.clear) |-> tk.tick_out;
   endproperty
   a_pre_div1: assert property (p_pre_div1) else $error("ratio one dropped a tick");
endmodule

/* hdl/tgc_edge.sv */
// rising edge finder for the external count source
// assumes the source is a level that may be async to clk
`timescale 1ns/1ns
module tgc_edge (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic src,
   input  wire logic bypass,
   input  wire logic enable,
   output logic      rise
);
   logic s1;
   logic s2;
   logic prev;
   logic armed;
   logic lvl;

   // two-flop synchroniser, s1 feeds only s2
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
      end else begin
         s1 <= src;
         s2 <= s1;
      end
   end

   // bypass skips the two-cycle delay, metastability is the user's risk
   assign lvl  = bypass ? src : s2;
   assign rise = enable & armed & ~prev & lvl;

   // a falling edge must be seen before the first counting edge
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev  <= 1'b0;
         armed <= 1'b0;
      end else begin
         prev  <= lvl;
         if (!enable) begin
            armed <= 1'b0;
         end else if (prev && !lvl) begin
            armed <= 1'b1;
         end
      end
   end

   property p_arm_first;
      @(posedge clk) disable iff (sys_rst) $rose(enable) |-> !rise;
   endproperty
   a_arm_first: assert property (p_arm_first) else $error("count before falling edge");

   property p_rise_after_fall;
      @(posedge clk) disable iff (sys_rst) rise |-> (armed && !prev && lvl);
   endproperty
   a_rise_after_fall: assert property (p_rise_after_fall) else $error("bad rising edge");
endmodule

/* dv/tgc_ext_src.sv */
// model of the far side: an external count source on the pin or the crystal line
// assumes the bench calls burst from its own thread; both lines idle low between bursts
`timescale 1ns/1ns
module tgc_ext_src (
   output logic pin,
   output logic xtal
);
   // both lines rest low outside a burst
   initial begin
      pin  = 1'b0;
      xtal = 1'b0;
   end
   // n full pulses, high for half clk cycles, low for half cycles plus 3 ns, so edges drift 3 ns later per pulse
   task automatic burst(input int n, input int half, input bit on_xtal);
      for (int i = 0; i < n; i++) begin
         #(half * 8 + 3);
         if (on_xtal)
            xtal = 1'b1;
         else
            pin = 1'b1;
         #(half * 8);
         if (on_xtal)
            xtal = 1'b0;
         else
            pin = 1'b0;
      end
   endtask
endmodule

/* dv/tgc_core_tb_top.sv */
// self-checking bench for the gated 16-bit timer/counter core
// assumes tgc_ext_src stands in for the external count source
`timescale 1ns/1ns
module tgc_core_tb_top;
   import tgc_pkg::*;
   logic       clk       = 1'b0;
   logic       sys_rst   = 1'b1;
   logic [2:0] reg_addr  = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr    = 1'b0;
   logic       reg_rd    = 1'b0;
   logic       no_clock_output_pin = 1'b0;
   logic       gate_pin  = 1'b0;
   logic       cmp_lvl   = 1'b0;
   logic       trig      = 1'b0;
   logic       sleep     = 1'b0;
   logic       rd_q      = 1'b0;
   logic [7:0] reg_rdata;
   logic       ext_pin, xtal, irq, wake, cmp_sync;
   int         fails     = 0;
   int         n_checks  = 0;
   int         cyc       = 0;
   logic [7:0] exp_q[$];
   string      nm_q[$];
   logic [15:0] tbl[8] = '{16'h4100, 16'h4124, 16'hc104, 16'h4160,
                           16'h4154, 16'h41d4, 16'h0108, 16'h0020};
   logic [7:0] ext[4] = '{8'h03, 8'h07, 8'h02, 8'h0f};

   always #4 clk = ~clk;

   tgc_core DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_count_input(ext_pin), .low_power_crystal_osc(xtal),
      .internal_oscillator_no_clock_output_pin(no_clock_output_pin), .gate_input_pin(gate_pin),
      .comparator_out(cmp_lvl), .special_event_trigger(trig), .sleep_mode(sleep),
      .irq(irq), .wake_req(wake), .comparator_sync_out(cmp_sync));
   tgc_ext_src SRC (.pin(ext_pin), .xtal(xtal));

   // verdict in one place
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   // read data stand one cycle only; the oldest note pairs with them
   always @(posedge clk) begin
      if (rd_q)
         chk(nm_q.pop_front(), exp_q.pop_front(), reg_rdata);
      else if (!sys_rst)
         chk("idle rdata", 8'h00, reg_rdata);
      rd_q <= reg_rd;
      cyc  <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         end_sim();
      end
   end

   // one-cycle strobes; a trigger may ride beside a write
   task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic t = 1'b0);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      trig      <= t;
      @(posedge clk);
      reg_wr <= 1'b0;
      trig   <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      exp_q.push_back(e);
      nm_q.push_back(nm);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask

   task automatic ld(input logic [15:0] v);
      wr(OFS_LOW, v[7:0]);
      wr(OFS_HIGH, v[15:8]);
   endtask

   // module on for exactly w cycles, so the tick count is independent of phase
   task automatic win(input logic [7:0] c, input int w);
      wr(OFS_CTRL, c);
      repeat (w - 2) @(posedge clk);
      wr(OFS_CTRL, 8'h00);
   endtask

   // main sequence
   initial begin
      int n;
      logic [15:0] r;
      void'($urandom(78440));
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 8; a++)
         rd(3'(a), 8'h00, "reset value");
      r = 16'($urandom);
      ld(r);
      rd(OFS_LOW, r[7:0], "count_low_byte");
      rd(OFS_HIGH, r[15:8], "count_high_byte");
      r[7:0] = 8'($urandom) & 8'hfe;
      wr(OFS_CTRL, r[7:0]);
      rd(OFS_CTRL, r[7:0], "ctrl");
      wr(OFS_CTRL, 8'h00);
      // three increments at each prescale ratio from instruction cycles
      for (int p = 0; p < 4; p++) begin
         ld(16'h0000);
         win(8'(1 | (p << 4)), 12 << p);
         rd(OFS_LOW, 8'h03, "count_low_byte");
      end
      // a counter write drops half-way prescaler progress at ratio eight
      ld(16'h0000);
      win(8'h31, 16);
      ld(16'h0000);
      win(8'h31, 16);
      rd(OFS_LOW, 8'h00, "prescaler cleared");
      // gate source, polarity, resync, sleep and off; resync row follows a cmp-high row
      foreach (tbl[i]) begin
         gate_pin <= tbl[i][5];
         cmp_lvl  <= tbl[i][4];
         sleep    <= tbl[i][3];
         wr(OFS_GATE, {6'h00, tbl[i][7:6]});
         ld(16'h0000);
         win(tbl[i][15:8], 16);
         sleep <= 1'b0;
         rd(OFS_LOW, {5'h00, tbl[i][2:0]}, "gated count");
      end
      // last sample taken in the resync row was high; sleep and off rows take none
      @(negedge clk);
      chk("comparator_sync_out", 8'h01, {7'h00, cmp_sync});
      // overflow sets the sticky flag; mask drives the level interrupt
      wr(OFS_MASK, 8'h01);
      ld(16'hffff);
      win(8'h01, 4);
      rd(OFS_HIGH, 8'h00, "count_high_byte");
      rd(OFS_STATUS, 8'h01, "overflow_flag");
      @(negedge clk);
      chk("irq", 8'h01, {7'h00, irq});
      wr(OFS_MASK, 8'h00);
      @(negedge clk);
      chk("irq masked", 8'h00, {7'h00, irq});
      wr(OFS_STATUS, 8'h01);
      rd(OFS_STATUS, 8'h00, "overflow_flag");
      // trigger clears without a flag, a coinciding write wins
      ld(16'hffff);
      wr(3'h7, 8'h00, 1'b1);
      rd(OFS_LOW, 8'h00, "count_low_byte");
      rd(OFS_HIGH, 8'h00, "count_high_byte");
      rd(OFS_STATUS, 8'h00, "overflow_flag");
      ld(16'h1234);
      wr(OFS_LOW, 8'h5a, 1'b1);
      rd(OFS_LOW, 8'h5a, "count_low_byte");
      rd(OFS_HIGH, 8'h12, "count_high_byte");
      // external edges: the first rise from idle low is not counted; its fall arms the counter
      no_clock_output_pin <= 1'b1;
      foreach (ext[i]) begin
         n = 3 + $urandom % 4;
         ld(16'h0000);
         wr(OFS_CTRL, ext[i]);
         SRC.burst(n, 3 + $urandom % 6, ext[i][3]);
         repeat (6) @(posedge clk);
         wr(OFS_CTRL, 8'h00);
         rd(OFS_LOW, ext[i][0] ? 8'(n - 1) : 8'h00, "ext count");
      end
      // asleep, unsynchronised external overflow requests a wake-up
      wr(OFS_MASK, 8'h01);
      ld(16'hffff);
      sleep <= 1'b1;
      wr(OFS_CTRL, 8'h07);
      SRC.burst(2, 4, 1'b0);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("wake_req", 8'h01, {7'h00, wake});
      wr(OFS_CTRL, 8'h03);
      @(negedge clk);
      chk("wake_req synced", 8'h00, {7'h00, wake});
      sleep <= 1'b0;
      wr(OFS_STATUS, 8'h01);
      @(negedge clk);
      chk("irq cleared", 8'h00, {7'h00, irq});
      @(posedge clk);
      @(posedge clk);
      end_sim();
   end
endmodule
